// ===== src/fault_pkg.sv
// Package for the fault indication encoder: register map, field positions,
// reset values and PWM error duty codes. Assumes a 32-bit AXI4-Lite bus.
package fault_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SETUP    = 8'h00;
  localparam logic [7:0] OFS_DIAG_EN  = 8'h04;
  localparam logic [7:0] OFS_PERIOD   = 8'h08;
  localparam logic [7:0] OFS_DUTY     = 8'h0C;
  localparam logic [7:0] OFS_FLAGS    = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_MASK     = 8'h18;
  localparam logic [7:0] OFS_OUTSTATE = 8'h1C;
  // customer_setup_register fields
  localparam int SETUP_LOCK   = 0;
  localparam int SETUP_DIAG   = 1;
  localparam int SETUP_LATCH  = 2;
  localparam int SETUP_OVDIS  = 3;
  localparam int SETUP_BAND   = 7;
  localparam int SETUP_PWMSEL = 10;
  // Diagnostic enable fields
  localparam int EN_OV     = 0;
  localparam int EN_MEMST  = 1;
  localparam int EN_PARITY = 2;
  localparam int EN_SMST   = 3;
  localparam int EN_ADDER  = 4;
  // Fault flag positions
  localparam int F_SELFTEST = 0;
  localparam int F_ADDER    = 1;
  localparam int F_OV       = 2;
  localparam int F_UV       = 3;
  localparam int F_THERM    = 4;
  localparam int F_WIREBRK  = 5;
  localparam int NFLAGS     = 6;
  // Reset values
  localparam logic [15:0] SETUP_RST  = 16'h0000;
  localparam logic [4:0]  DIAG_RST   = 5'h00;
  localparam logic [15:0] PERIOD_RST = 16'h00FA;
  localparam logic [15:0] DUTY_RST   = 16'h007D;
  // Error duty codes in percent
  localparam logic [6:0] DUTY_SELFTEST = 7'd95;
  localparam logic [6:0] DUTY_ADDER    = 7'd85;
  localparam logic [6:0] DUTY_OV       = 7'd75;
  localparam logic [6:0] DUTY_UV       = 7'd100;
  // Prescaler: one PWM tick every PRESCALE clocks
  localparam logic [7:0] PRESCALE = 8'd125;
  // Output drive modes
  typedef enum logic [1:0] {DRV_PWM, DRV_HIGH, DRV_LOW, DRV_TRI} drive_t;
endpackage

// ===== src/fault_sync_if.sv
// Interface carrying synchronised fault inputs into the encoder core.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface fault_sync_if;
  logic [7:0] raw;
  logic [7:0] clean;
  modport src (input raw, output clean);
  modport dst (output raw, input clean);
endinterface
`default_nettype wire

// ===== src/fault_input_sync.sv
// Three-stage synchroniser for asynchronous fault detector inputs.
// A change is accepted when the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module fault_input_sync (
  // Clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // Fault lines
  fault_sync_if.src   fs
);
  logic [7:0] s1;
  logic [7:0] s2;
  logic [7:0] s3;
  logic [7:0] held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1   <= 8'h00;
      s2   <= 8'h00;
      s3   <= 8'h00;
      held <= 8'h00;
    end else begin
      s1 <= fs.raw;
      s2 <= s1;
      s3 <= s2;
      held <= (s2 & s3) | (held & (s2 | s3));
    end
  end

  assign fs.clean = held;
endmodule
`default_nettype wire

// ===== src/fault_indication_encoder.sv
// Fault indication encoder: gathers diagnostic results and overrides the
// sensor output with error band or coded PWM; AXI4-Lite register slave.
// Assumes detector inputs are asynchronous and aclk runs at 125 MHz.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fault_indication_encoder (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Fault detector inputs, asynchronous
  input  wire logic        over_voltage,
  input  wire logic        under_voltage,
  input  wire logic        mem_selftest_fail,
  input  wire logic        rom_parity_fail,
  input  wire logic        sm_selftest_fail,
  input  wire logic        adder_overflow,
  input  wire logic        over_temp,
  input  wire logic        supply_pin_break,
  // Variant select
  input  wire logic        pwm_variant,
  // Sensor output pin
  output logic             out_o,
  output logic             out_oe,
  // Interrupt
  output logic             irq
);
  // Registers
  logic [15:0]              customer_setup_register;
  logic [4:0]               diag_enable;
  logic [15:0]              pwm_period;
  logic [15:0]              pwm_duty;
  logic [fault_pkg::NFLAGS-1:0] flags;
  logic [fault_pkg::NFLAGS-1:0] irq_status;
  logic [fault_pkg::NFLAGS-1:0] irq_mask;

  // Synchronised inputs
  fault_sync_if fsi ();
  assign fsi.raw = {over_temp, supply_pin_break, adder_overflow, sm_selftest_fail,
                    rom_parity_fail, mem_selftest_fail, under_voltage, over_voltage};
  fault_input_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fs      (fsi)
  );

  // Customer enables gate each optional diagnostic; undervoltage is always on
  wire        en_ov      = diag_enable[fault_pkg::EN_OV] & ~customer_setup_register[fault_pkg::SETUP_OVDIS];
  wire        en_mem     = diag_enable[fault_pkg::EN_MEMST];
  wire        en_par     = diag_enable[fault_pkg::EN_PARITY];
  wire        en_sm      = diag_enable[fault_pkg::EN_SMST];
  wire        en_add     = diag_enable[fault_pkg::EN_ADDER];

  // Synchronised detector levels, named in the order packed into the interface
  wire        ov_sync    = fsi.clean[0];
  wire        uv_sync    = fsi.clean[1];
  wire        mem_sync   = fsi.clean[2];
  wire        rom_sync   = fsi.clean[3];
  wire        sm_sync    = fsi.clean[4];
  wire        add_sync   = fsi.clean[5];
  wire        brk_sync   = fsi.clean[6];
  wire        therm_sync = fsi.clean[7];

  wire [fault_pkg::NFLAGS-1:0] live;
  assign live[fault_pkg::F_SELFTEST] = (mem_sync & en_mem) | (rom_sync & en_par) |
                                       (sm_sync & en_sm);
  assign live[fault_pkg::F_ADDER]    = add_sync & en_add;
  assign live[fault_pkg::F_OV]       = ov_sync & en_ov;
  assign live[fault_pkg::F_UV]       = uv_sync;
  assign live[fault_pkg::F_THERM]    = therm_sync;
  assign live[fault_pkg::F_WIREBRK]  = brk_sync;

  // Latched flags clear at reset or when software clears the SETUP_LATCH bit
  wire latch_mode = customer_setup_register[fault_pkg::SETUP_LATCH];
  wire [fault_pkg::NFLAGS-1:0] next_flags = latch_mode ? (flags | live) : live;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  // Effective flags: live value joins immediately so indication is not delayed
  wire [fault_pkg::NFLAGS-1:0] eff = flags | live;
  wire diag_fault  = eff[fault_pkg::F_SELFTEST] | eff[fault_pkg::F_ADDER] | eff[fault_pkg::F_OV];
  wire diag_force  = diag_fault & ~customer_setup_register[fault_pkg::SETUP_DIAG];
  wire err_any     = diag_force | eff[fault_pkg::F_UV];
  wire locked      = customer_setup_register[fault_pkg::SETUP_LOCK];
  wire band_low    = locked & customer_setup_register[fault_pkg::SETUP_BAND];

  // PWM error duty in percent, highest priority first
  logic [6:0] err_pct;
  always_comb begin
    if (diag_force && eff[fault_pkg::F_SELFTEST]) begin
      err_pct = fault_pkg::DUTY_SELFTEST;
    end else if (diag_force && eff[fault_pkg::F_ADDER]) begin
      err_pct = fault_pkg::DUTY_ADDER;
    end else if (diag_force && eff[fault_pkg::F_OV]) begin
      err_pct = fault_pkg::DUTY_OV;
    end else begin
      err_pct = fault_pkg::DUTY_UV;
    end
  end

  // PWM tick prescaler
  // One tick per microsecond at the nominal clock rate
  logic [7:0] pre_cnt;
  wire        tick = (pre_cnt == fault_pkg::PRESCALE - 8'd1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt <= 8'h00;
    end else begin
      pre_cnt <= tick ? 8'h00 : pre_cnt + 8'd1;
    end
  end

  // PWM counter; period doubled in error mode
  // Error duty is cut down to whole ticks, so short periods lose resolution
  logic [16:0] pwm_cnt;
  wire  [16:0] period_eff = err_any ? {pwm_period, 1'b0} : {1'b0, pwm_period};
  wire  [23:0] err_thr_w  = period_eff * err_pct;
  wire  [16:0] err_thr    = 17'(err_thr_w / 24'd100);
  wire  [16:0] thr        = err_any ? err_thr : {1'b0, pwm_duty};
  wire         at_end     = (pwm_cnt >= period_eff - 17'd1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt <= 17'h0_0000;
    end else if (tick) begin
      pwm_cnt <= at_end ? 17'h0_0000 : pwm_cnt + 17'd1;
    end
  end
  wire pwm_active = (err_any && err_pct == fault_pkg::DUTY_UV) ? 1'b1 : (pwm_cnt < thr);
  wire pwm_level  = pwm_active ^ (locked & customer_setup_register[fault_pkg::SETUP_BAND]);

  // Output drive selection
  // Over temperature wins over wire break, which wins over any error indication
  fault_pkg::drive_t drive;
  always_comb begin
    if (eff[fault_pkg::F_THERM]) begin
      drive = fault_pkg::DRV_TRI;
    end else if (eff[fault_pkg::F_WIREBRK]) begin
      drive = fault_pkg::DRV_LOW;
    end else if (err_any && !pwm_variant) begin
      drive = band_low ? fault_pkg::DRV_LOW : fault_pkg::DRV_HIGH;
    end else begin
      drive = fault_pkg::DRV_PWM;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_o  <= 1'b0;
      out_oe <= 1'b0;
    end else begin
      case (drive)
        fault_pkg::DRV_TRI: begin
          out_o  <= 1'b0;
          out_oe <= 1'b0;
        end
        fault_pkg::DRV_LOW: begin
          out_o  <= 1'b0;
          out_oe <= 1'b1;
        end
        fault_pkg::DRV_HIGH: begin
          out_o  <= 1'b1;
          out_oe <= 1'b1;
        end
        default: begin
          out_o  <= pwm_level;
          out_oe <= 1'b1;
        end
      endcase
    end
  end

  // Interrupt status: rising of effective flags, set wins over clear
  logic [fault_pkg::NFLAGS-1:0] eff_q;
  wire  [fault_pkg::NFLAGS-1:0] ev = eff & ~eff_q;

  // AXI4-Lite write channel
  // Address and data may come on different edges; the first half is held
  logic       aw_hold;
  logic       w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
  wire aw_go = s_axi_awvalid & s_axi_awready;
  wire w_go  = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_hold | aw_go;
  wire have_w  = w_hold | w_go;
  wire [7:0]  wa   = aw_hold ? aw_addr : s_axi_awaddr;
  wire [31:0] wd   = w_hold ? w_data : s_axi_wdata;
  wire [3:0]  ws   = w_hold ? w_strb : s_axi_wstrb;
  wire        wr   = have_aw & have_w & ~s_axi_bvalid;
  wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire wr_setup  = wr & (wa == fault_pkg::OFS_SETUP);
  wire wr_diag   = wr & (wa == fault_pkg::OFS_DIAG_EN);
  wire wr_period = wr & (wa == fault_pkg::OFS_PERIOD);
  wire wr_duty   = wr & (wa == fault_pkg::OFS_DUTY);
  wire wr_status = wr & (wa == fault_pkg::OFS_STATUS);
  wire wr_mask   = wr & (wa == fault_pkg::OFS_MASK);
  wire wr_ok     = wr_setup | wr_diag | wr_period | wr_duty | wr_status | wr_mask |
                   (wa == fault_pkg::OFS_FLAGS) | (wa == fault_pkg::OFS_OUTSTATE);
  wire [31:0] wm = wd & wmask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (aw_go && !wr) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_go && !wr) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      customer_setup_register <= fault_pkg::SETUP_RST;
      diag_enable <= fault_pkg::DIAG_RST;
      pwm_period  <= fault_pkg::PERIOD_RST;
      pwm_duty    <= fault_pkg::DUTY_RST;
      irq_mask    <= '0;
      irq_status  <= '0;
      eff_q       <= '0;
    end else begin
      eff_q <= eff;
      if (wr_setup) begin
        customer_setup_register <= (customer_setup_register & ~wmask[15:0]) | wm[15:0];
      end
      if (wr_diag) begin
        diag_enable <= (diag_enable & ~wmask[4:0]) | wm[4:0];
      end
      if (wr_period) begin
        pwm_period <= (pwm_period & ~wmask[15:0]) | wm[15:0];
      end
      if (wr_duty) begin
        pwm_duty <= (pwm_duty & ~wmask[15:0]) | wm[15:0];
      end
      if (wr_mask) begin
        irq_mask <= (irq_mask & ~wmask[fault_pkg::NFLAGS-1:0]) | wm[fault_pkg::NFLAGS-1:0];
      end
      irq_status <= (irq_status & ~(wr_status ? wm[fault_pkg::NFLAGS-1:0] : '0)) | ev;
    end
  end


  // Level interrupt: high while any unmasked status bit is set
  assign irq = |(irq_status & irq_mask);

  // AXI4-Lite read channel
  // Read data is captured when the address is taken and stands until rready
  assign s_axi_arready = ~s_axi_rvalid;
  logic [31:0] rsel;
  logic        rok;
  always_comb begin
    rok  = 1'b1;
    rsel = 32'h0000_0000;
    case (s_axi_araddr)
      fault_pkg::OFS_SETUP:    rsel = {16'h0000, customer_setup_register};
      fault_pkg::OFS_DIAG_EN:  rsel = {27'h000_0000, diag_enable};
      fault_pkg::OFS_PERIOD:   rsel = {16'h0000, pwm_period};
      fault_pkg::OFS_DUTY:     rsel = {16'h0000, pwm_duty};
      fault_pkg::OFS_FLAGS:    rsel = {26'h000_0000, flags};
      fault_pkg::OFS_STATUS:   rsel = {26'h000_0000, irq_status};
      fault_pkg::OFS_MASK:     rsel = {26'h000_0000, irq_mask};
      fault_pkg::OFS_OUTSTATE: rsel = {28'h000_0000, drive, out_oe, out_o};
      default:                 rok  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rsel;
      s_axi_rresp  <= rok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== tb/fault_encoder_checker.sv
// Checker: bus handshake order and fault overrides of the encoder.
// Sees top ports only; bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module fault_encoder_checker (
  // Bus
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Fault pins and output
  input wire logic        over_temp,
  input wire logic        supply_pin_break,
  input wire logic        out_o,
  input wire logic        out_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response missing");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
  a_therm_tristate: assert property (over_temp [*8] |-> !out_oe)
    else $error("output driven in over temperature");
  a_break_ground: assert property ((supply_pin_break && !over_temp) [*8] |-> out_oe && !out_o)
    else $error("output not at ground on wire break");
  c_therm: cover property (over_temp && !out_oe);
  c_break: cover property (supply_pin_break && out_oe && !out_o);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// ===== tb/control_unit_model.sv
// Control unit reading the sensor line through an external pull-up;
// measures each PWM period between rising edges.
`timescale 1ns/1ps
`default_nettype none
module control_unit_model (
  input  wire logic aclk,
  input  wire logic out_o,
  input  wire logic out_oe,
  output logic      line,
  output var int    period_clks,
  output var int    high_clks,
  output var int    rises
);
  int   cnt = 0;
  int   hcnt = 0;
  logic prev = 1'b1;
  // Released line floats up to the supply
  assign line = out_oe ? out_o : 1'b1;
  initial rises = 0;
  always @(posedge aclk) begin
    prev <= line;
    if (line && !prev) begin
      period_clks <= cnt;
      high_clks   <= hcnt;
      rises       <= rises + 1;
      cnt         <= 1;
      hcnt        <= 1;
    end else begin
      cnt  <= cnt + 1;
      hcnt <= hcnt + int'(line);
    end
  end
endmodule
`default_nettype wire

// ===== tb/fault_indication_encoder_tb.sv
// Testbench: AXI4-Lite master tasks and one task per scenario.
// Assumes a 125 MHz clock and a pulled-up sensor line.
`timescale 1ns/1ps
`default_nettype none
module fault_indication_encoder_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        pwm_variant = 1'b0;
  logic [7:0]  flt = 8'h00;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        out_o, out_oe, irq, line;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, d;
  wire         over_voltage, under_voltage, mem_selftest_fail, rom_parity_fail;
  wire         sm_selftest_fail, adder_overflow, over_temp, supply_pin_break;
  int          period_clks, high_clks, rises;
  int          bad_count = 0;
  int          samples_checked = 0;
  assign {supply_pin_break, over_temp, adder_overflow, sm_selftest_fail,
          rom_parity_fail, mem_selftest_fail, under_voltage, over_voltage} = flt;
  fault_indication_encoder u_dut (.*);
  control_unit_model u_cu (.aclk(aclk), .out_o(out_o), .out_oe(out_oe), .line(line),
                           .period_clks(period_clks), .high_clks(high_clks), .rises(rises));
  initial forever #4 aclk = ~aclk;
  task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One write (w=1) or read; e is the expected response code
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_bready  <= w;
    s_axi_arvalid <= !w;
    s_axi_rready  <= !w;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 100);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    check("resp", w ? s_axi_bresp : s_axi_rresp, e);
    if (n >= 100) begin
      check("bus timeout", 0, 1);
      tally_and_finish();
    end
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge aclk);
    flt <= v;
    repeat (8) @(posedge aclk);
  endtask
  task automatic measure(input int p, input int h);
    int n, r0;
    r0 = rises;
    n = 0;
    while (rises < r0 + 3 && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    check("pwm period", period_clks, p);
    check("pwm high", high_clks, h);
    if (n >= 20000) begin
      check("pwm timeout", 0, 1);
      tally_and_finish();
    end
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic sc_regs();
    bus(0, 8'h08, 0, 2'b00);
    check("period reset", d, 32'h0000_00FA);
    bus(0, 8'h0C, 0, 2'b00);
    check("duty reset", d, 32'h0000_007D);
    bus(1, 8'h40, 32'h0000_0001, 2'b10);
    bus(0, 8'h40, 0, 2'b10);
    check("unmapped data", d, 32'h0000_0000);
  endtask
  task automatic sc_override();
    int pin[5] = '{0, 2, 3, 4, 5};
    for (int i = 0; i < 5; i++) begin
      bus(1, 8'h04, 32'h0000_001F ^ (32'h0000_0001 << i), 2'b00);
      pins(8'h01 << pin[i]);
      bus(0, 8'h1C, 0, 2'b00);
      check("band off", d[3:2] == 2'd1, 1'b0);
      bus(1, 8'h04, 32'h0000_0001 << i, 2'b00);
      bus(0, 8'h1C, 0, 2'b00);
      check("band on", d[3:2] == 2'd1, 1'b1);
      pins(8'h00);
    end
    bus(1, 8'h04, 32'h0000_001F, 2'b00);
    bus(1, 8'h00, 32'h0000_0080, 2'b00);
    pins(8'h04);
    check("unlocked band", {out_oe, out_o}, 2'b11);
    bus(1, 8'h00, 32'h0000_0082, 2'b00);
    bus(0, 8'h1C, 0, 2'b00);
    check("diag off", d[3:2] == 2'd1, 1'b0);
    bus(1, 8'h00, 32'h0000_0081, 2'b00);
    bus(0, 8'h1C, 0, 2'b00);
    check("low band", d[3:0], 4'hA);
    pins(8'h00);
  endtask
  task automatic sc_pwm();
    logic [7:0] f[7] = '{8'h00, 8'h04, 8'h20, 8'h01, 8'h27, 8'h23, 8'h03};
    int         h[7] = '{625, 2375, 2125, 1875, 2375, 2125, 1875};
    int         r0;
    pwm_variant <= 1'b1;
    bus(1, 8'h08, 32'h0000_000A, 2'b00);
    bus(1, 8'h0C, 32'h0000_0005, 2'b00);
    bus(1, 8'h04, 32'h0000_001F, 2'b00);
    for (int i = 0; i < 7; i++) begin
      pins(f[i]);
      measure(f[i] == 8'h00 ? 1250 : 2500, h[i]);
    end
    pins(8'h02);
    r0 = rises;
    repeat (3000) @(posedge aclk);
    check("uv edges", rises, r0);
    check("uv level", line, 1'b1);
    pins(8'h00);
  endtask
  task automatic sc_irq_latch();
    pwm_variant <= 1'b0;
    pins(8'h40);
    check("therm oe", out_oe, 1'b0);
    check("masked irq", irq, 1'b0);
    pins(8'hC0);
    check("therm first", out_oe, 1'b0);
    pins(8'h80);
    check("break level", {out_oe, out_o}, 2'b10);
    bus(1, 8'h18, 32'h0000_0010, 2'b00);
    repeat (2) @(posedge aclk);
    check("irq on", irq, 1'b1);
    bus(1, 8'h14, 32'h0000_0010, 2'b00);
    repeat (2) @(posedge aclk);
    check("irq clear", irq, 1'b0);
    bus(1, 8'h04, 32'h0000_0010, 2'b00);
    for (int l = 0; l < 2; l++) begin
      bus(1, 8'h00, l << 2, 2'b00);
      pins(8'h20);
      pins(8'h00);
      bus(0, 8'h10, 0, 2'b00);
      check("adder flag", d[1], l);
    end
  endtask
  initial begin
    do_reset();
    sc_regs();
    sc_override();
    do_reset();
    sc_pwm();
    do_reset();
    sc_irq_latch();
    tally_and_finish();
  end
endmodule
bind fault_indication_encoder fault_encoder_checker u_chk (.*);
`default_nettype wire
